// file: hdl/pdl_pkg.sv
// Constants for the device and link control register bank
package pdl_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] PDL_OFF_DEVCTL  = 12'h088;
    localparam logic [11:0] PDL_OFF_LNKCAP  = 12'h08C;
    localparam logic [11:0] PDL_OFF_LNKCTL  = 12'h090;
    localparam logic [11:0] PDL_OFF_DEVCAP2 = 12'h0A4;
    localparam logic [11:0] PDL_OFF_DEVCTL2 = 12'h0A8;
    localparam logic [11:0] PDL_OFF_LNKCAP2 = 12'h0AC;
    localparam logic [11:0] PDL_OFF_LNKCTL2 = 12'h0B0;
    localparam logic [11:0] PDL_OFF_INTSTAT = 12'h0C0;
    localparam logic [11:0] PDL_OFF_INTMASK = 12'h0C4;
    // ==========================================================
    // Writable and sticky masks, reset values and bit positions
    localparam logic [31:0] PDL_DEVCTL_WMASK  = 32'h0000_79FF;
    localparam logic [31:0] PDL_DEVCTL_RST    = 32'h0000_2800;
    localparam int          PDL_DEVCTL_FLR    = 15;
    localparam int          PDL_DEVSTA_ERR0   = 16;
    localparam int          PDL_DEVSTA_TXPEND = 21;
    localparam logic [31:0] PDL_LNKCTL_WMASK  = 32'h0000_00CB;
    localparam logic [31:0] PDL_DEVCTL2_WMASK = 32'h0000_005F;
    localparam logic [31:0] PDL_DEVCTL2_RST   = 32'h0000_001F;
    localparam logic [31:0] PDL_LNKCTL2_SMASK = 32'h0000_FF9F;
    localparam logic [31:0] PDL_LNKCTL2_WMASK = 32'h0000_0020;
    localparam logic [31:0] PDL_LNKCTL2_RST   = 32'h0000_0001;
    localparam int          PDL_LNKSTA2_EQREQ = 21;
    localparam int          PDL_LNKCAP_L0S    = 10;
    localparam int          PDL_LNKCAP_L1     = 11;
    localparam int          PDL_FLR_CAP_BIT   = 28;
    // ==========================================================
    // Interrupt sources: 4 error flags, equalization request
    localparam int          PDL_NIRQ          = 5;
    localparam logic [4:0]  PDL_IRQ_RST       = 5'h00;
endpackage

// file: hdl/pdl_w1c.sv
// Sticky write-one-to-clear flag bank
`timescale 1ns/1ps
module pdl_w1c
    import pdl_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] set_in,
    input  wire logic [WIDTH-1:0] clr_in,
    output logic      [WIDTH-1:0] flag_out
);
    initial begin
        if (WIDTH < 1) $error("pdl_w1c: WIDTH must be at least 1");
    end
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // ==========================================================
            // Set beats clear so a coincident event is never lost
            always_ff @(posedge mclk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    flag_out[i] <= 1'b0;
                end else if (ce_in) begin
                    flag_out[i] <= set_in[i] | (flag_out[i] & ~clr_in[i]);
                end
            end
        end
    endgenerate
endmodule

// file: hdl/pdl_regs.sv
// Device and link control/status register bank of an endpoint function
//
// Functional notes
// RULE1: Error reporting enables bits 0-2 read-write; detected flags 16-18 write-one-clear.
// RULE2: Unsupported request enable bit 3; detected flag bit 19, write-one-clear.
// RULE3: Extended tag enable bit 8 read-write, resets to zero.
// RULE4: Max read request size bits 14:12 read-write, resets to 2.
// RULE5: Writing one to bit 15 starts function reset only if capable.
// RULE6: Function reset trigger bit always reads zero.
// RULE7: Transaction pending bit 21 follows outstanding non-posted requests.
// RULE8: ASPM L0s and L1 support bits 10, 11 read-only strap values.
// RULE9: Timeout ranges/disable support in caps 2; control 2 resets to 0xF, 1.
// RULE10: Atomic requester enable bit 6 of control 2, resets to zero.
// RULE11: Autonomous speed disable bit 5 of link control 2, resets to zero.
// RULE12: Equalization status bits 17-20 read-only; request bit 21 write-one-clear.
// RULE13: Reserved bits read zero and ignore writes.
// RULE14: Sticky link control 2 fields survive function and conventional resets.
`timescale 1ns/1ps
module pdl_regs
    import pdl_pkg::*;
#(
    parameter int          AW        = 12,
    parameter logic [31:0] LNKCAP_V  = 32'h0040_6C11,
    parameter logic [31:0] DEVCAP_V  = 32'h1000_0000,
    parameter logic [31:0] DEVCAP2_V = 32'h0000_001F,
    parameter logic [31:0] LNKCAP2_V = 32'h0000_0002
) (
    input  wire logic          mclk_in,
    input  wire logic          rst_n_in,
    input  wire logic          por_n_in,
    input  wire logic          ce_in,
    input  wire logic [AW-1:0] addr_in,
    input  wire logic [31:0]   wdata_in,
    input  wire logic          wr_in,
    input  wire logic          rd_in,
    output logic      [31:0]   rdata_out,
    input  wire logic [3:0]    err_event_in,
    input  wire logic          np_pending_in,
    input  wire logic [9:0]    link_state_in,
    input  wire logic [3:0]    eq_status_in,
    input  wire logic          eq_request_in,
    output logic               flr_out,
    output logic               irq_out,
    output logic [31:0]        devctl_out,
    output logic [31:0]        devctl2_out,
    output logic [31:0]        lnkctl_out,
    output logic [31:0]        lnkctl2_out
);
    initial begin
        if (AW < 8) $error("pdl_regs: AW must be at least 8");
    end

    // ==========================================================
    // Decode
    wire logic [11:0] a12      = 12'(addr_in);
    wire logic        wr_dev   = ce_in & wr_in & (a12 == PDL_OFF_DEVCTL);
    wire logic        wr_lnk   = ce_in & wr_in & (a12 == PDL_OFF_LNKCTL);
    wire logic        wr_dev2  = ce_in & wr_in & (a12 == PDL_OFF_DEVCTL2);
    wire logic        wr_lnk2  = ce_in & wr_in & (a12 == PDL_OFF_LNKCTL2);
    wire logic        wr_ist   = ce_in & wr_in & (a12 == PDL_OFF_INTSTAT);
    wire logic        wr_imsk  = ce_in & wr_in & (a12 == PDL_OFF_INTMASK);
    wire logic        flr_cap  = DEVCAP_V[PDL_FLR_CAP_BIT];

    // ==========================================================
    // Status inputs come from core logic on this clock: no sync
    logic [31:0] devctl_q;
    logic [31:0] lnkctl_q;
    logic [31:0] devctl2_q;
    logic [31:0] lnkctl2_q;
    logic [31:0] rdata_q;
    logic        flr_q;
    logic        irq_q;
    logic        txpend_q;
    logic [9:0]  lsta_q;
    logic [3:0]  eqsta_q;
    logic [4:0]  imask_q;
    logic [3:0]  errflag;
    logic        eqflag;
    logic [4:0]  istat;

    // ==========================================================
    // Sticky event flags
    pdl_w1c #(.WIDTH(4)) u_err (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .set_in   (err_event_in),
        .clr_in   (wr_dev ? wdata_in[PDL_DEVSTA_ERR0 +: 4] : 4'h0), // RULE1 RULE2
        .flag_out (errflag)
    );
    pdl_w1c #(.WIDTH(1)) u_eq (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .set_in   (eq_request_in),
        .clr_in   (wr_lnk2 & wdata_in[PDL_LNKSTA2_EQREQ]), // RULE12
        .flag_out (eqflag)
    );
    pdl_w1c #(.WIDTH(PDL_NIRQ)) u_ist (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .ce_in    (ce_in),
        .set_in   ({eq_request_in, err_event_in}),
        .clr_in   (wr_ist ? wdata_in[PDL_NIRQ-1:0] : PDL_IRQ_RST),
        .flag_out (istat)
    );

    // ==========================================================
    // Control registers; reserved bits masked on write
    wire logic [31:0] devctl_d  = (wdata_in & PDL_DEVCTL_WMASK) | (devctl_q & ~PDL_DEVCTL_WMASK); // RULE13
    wire logic [31:0] lnkctl_d  = wdata_in & PDL_LNKCTL_WMASK; // RULE13
    wire logic [31:0] devctl2_d = wdata_in & PDL_DEVCTL2_WMASK; // RULE10
    wire logic [31:0] lnk2_wd   = wdata_in & PDL_LNKCTL2_WMASK; // RULE11
    wire logic [31:0] lnk2_sd   = wdata_in & PDL_LNKCTL2_SMASK; // RULE14
    wire logic        flr_d     = wr_dev & wdata_in[PDL_DEVCTL_FLR] & flr_cap; // RULE5

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            devctl_q  <= PDL_DEVCTL_RST; // RULE1 RULE3 RULE4
            lnkctl_q  <= 32'h0000_0000;
            devctl2_q <= PDL_DEVCTL2_RST; // RULE9
            flr_q     <= 1'b0;
        end else if (ce_in) begin
            if (wr_dev) begin
                devctl_q <= devctl_d;
            end
            if (wr_lnk) begin
                lnkctl_q <= lnkctl_d;
            end
            if (wr_dev2) begin
                devctl2_q <= devctl2_d;
            end
            flr_q <= flr_d; // RULE5
        end
    end

    // Non-sticky half of link control 2
    logic [31:0] lnk2w_q;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lnk2w_q <= 32'h0000_0000; // RULE11
        end else if (ce_in && wr_lnk2) begin
            lnk2w_q <= lnk2_wd;
        end
    end

    // Sticky half: only power-on reset touches it
    logic [31:0] lnk2s_q;
    always_ff @(posedge mclk_in or negedge por_n_in) begin
        if (!por_n_in) begin
            lnk2s_q <= PDL_LNKCTL2_RST; // RULE14
        end else if (ce_in && wr_lnk2) begin
            lnk2s_q <= lnk2_sd;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            txpend_q <= 1'b0;
            lsta_q   <= 10'h000;
            eqsta_q  <= 4'h0;
            imask_q  <= PDL_IRQ_RST;
            irq_q    <= 1'b0;
        end else if (ce_in) begin
            txpend_q <= np_pending_in; // RULE7
            lsta_q   <= link_state_in;
            eqsta_q  <= eq_status_in; // RULE12
            if (wr_imsk) begin
                imask_q <= wdata_in[PDL_NIRQ-1:0];
            end
            irq_q <= |(istat & imask_q);
        end
    end

    // ==========================================================
    // Read composition
    wire logic [31:0] devcs_rd = {10'h000, txpend_q, 1'b0, errflag, 1'b0, devctl_q[14:0]}; // RULE6 RULE7
    wire logic [31:0] lnkcs_rd = {6'h00, lsta_q, 8'h00, lnkctl_q[7:0]};
    wire logic [31:0] lnk2_rd  = {10'h000, eqflag, eqsta_q, 1'b0, lnk2s_q[15:0] | lnk2w_q[15:0]}; // RULE12
    wire logic [31:0] cap_rd   = LNKCAP_V & 32'h007F_FFFF; // RULE8
    logic [31:0] rd_mux;
    always_comb begin
        case (a12)
            PDL_OFF_DEVCTL:  rd_mux = devcs_rd;
            PDL_OFF_LNKCAP:  rd_mux = cap_rd;
            PDL_OFF_LNKCTL:  rd_mux = lnkcs_rd;
            PDL_OFF_DEVCAP2: rd_mux = DEVCAP2_V & 32'h0000_001F; // RULE9
            PDL_OFF_DEVCTL2: rd_mux = devctl2_q;
            PDL_OFF_LNKCAP2: rd_mux = LNKCAP2_V & 32'h0000_000E;
            PDL_OFF_LNKCTL2: rd_mux = lnk2_rd;
            PDL_OFF_INTSTAT: rd_mux = {27'h0000000, istat};
            PDL_OFF_INTMASK: rd_mux = {27'h0000000, imask_q};
            default:         rd_mux = 32'h0000_0000; // RULE13
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (ce_in) begin
            rdata_q <= rd_in ? rd_mux : 32'h0000_0000;
        end
    end

    assign rdata_out   = rdata_q;
    assign flr_out     = flr_q;
    assign irq_out     = irq_q;
    assign devctl_out  = {16'h0000, 1'b0, devctl_q[14:0]};
    assign devctl2_out = devctl2_q;
    assign lnkctl_out  = lnkctl_q;
    assign lnkctl2_out = lnk2s_q | lnk2w_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    AST_ERR_SET: assert property (ce_in && err_event_in[0] |=> errflag[0]) // RULE1
        else $error("correctable flag not set");
    AST_UR_CLR: assert property (ce_in && wr_dev && wdata_in[19] && !err_event_in[3] |=> !errflag[3]) // RULE2
        else $error("UR flag not cleared");
    AST_FLR_PULSE: assert property (ce_in && wr_dev && wdata_in[15] |=> flr_out == flr_cap) // RULE5
        else $error("function reset pulse wrong");
    AST_FLR_RD0: assert property (ce_in && rd_in && a12 == PDL_OFF_DEVCTL |=> !rdata_out[15]) // RULE6
        else $error("trigger bit read nonzero");
    AST_TXPEND: assert property (ce_in ##1 ce_in && rd_in && a12 == PDL_OFF_DEVCTL
                                 |=> rdata_out[21] == $past(np_pending_in, 2)) // RULE7
        else $error("pending bit mismatch");
    AST_RSVD: assert property (ce_in && rd_in && a12 == PDL_OFF_DEVCTL2 |=> rdata_out[31:7] == 25'h0 && !rdata_out[5]) // RULE13
        else $error("reserved bits nonzero");
    AST_EQ_SET: assert property (ce_in && eq_request_in |=> eqflag) // RULE12
        else $error("eq request not latched");
    AST_MRRS: assert property (ce_in && wr_dev |=> devctl_out[14:12] == $past(wdata_in[14:12])) // RULE4
        else $error("read request size not written");
    AST_HASD: assert property (ce_in && wr_lnk2 |=> lnkctl2_out[5] == $past(wdata_in[5])) // RULE11
        else $error("speed disable not written");
    AST_IRQ: assert property (ce_in [*2] ##0 |(istat & imask_q) |=> irq_out) // RULE1
        else $error("irq not raised");

    CV_FLR: cover property (flr_out);
    CV_IRQ: cover property (irq_out);
    CV_EQ_CLR: cover property (eqflag ##1 !eqflag);
    CV_RD: cover property (rd_in ##1 rdata_out != 32'h0);
endmodule

// file: bench/pdl_core_model.sv
// Core-side status source that feeds the register bank
`timescale 1ns/1ps
module pdl_core_model #(
    parameter logic [9:0] LINK_STATE = 10'h043
) (
    input  wire logic       mclk_in,
    input  wire logic       por_n_in,
    input  wire logic [3:0] err_cmd_in,
    input  wire logic       eqreq_cmd_in,
    input  wire logic       pend_cmd_in,
    input  wire logic [3:0] eqst_cmd_in,
    output logic      [3:0] err_event_out,
    output logic            np_pending_out,
    output logic      [9:0] link_state_out,
    output logic      [3:0] eq_status_out,
    output logic            eq_request_out
);
    // ==========================================================
    // Status lines
    // Cleared by power-on only, so event and status lines survive a function reset; link state is a constant
    always_ff @(posedge mclk_in or negedge por_n_in) begin
        if (!por_n_in) begin
            err_event_out  <= 4'h0;
            np_pending_out <= 1'b0;
            eq_status_out  <= 4'h0;
            eq_request_out <= 1'b0;
        end else begin
            err_event_out  <= err_cmd_in;
            np_pending_out <= pend_cmd_in;
            eq_status_out  <= eqst_cmd_in;
            eq_request_out <= eqreq_cmd_in;
        end
    end
    assign link_state_out = LINK_STATE;
endmodule

// file: bench/tb_pcie_device_link_control_regs.sv
// Self-checking testbench for the device and link register bank
`timescale 1ns/1ps
module tb_pcie_device_link_control_regs
    import pdl_pkg::*;
;
    // ==========================================================
    // Signals
    localparam logic [31:0] LNKCAP_T = 32'h0040_6C11;
    localparam logic [9:0]  LINK_T   = 10'h043;
    logic        mclk_in = 1'b0, rst_n_in = 1'b0, por_n_in = 1'b0;
    logic        wr_in = 1'b0, rd_in = 1'b0, rd_seen = 1'b0, eqreq_cmd = 1'b0, pend_cmd = 1'b0;
    logic [11:0] addr_in = 12'h000;
    logic [31:0] wdata_in = 32'h0, lfsr = 32'hE590, v, rdata_out;
    logic [3:0]  err_cmd = 4'h0, eqst_cmd = 4'h0, err_ev, eq_st;
    logic [9:0]  link_st;
    logic        np_pend, eq_req, flr_out, irq_out;
    logic [31:0] devctl_out, devctl2_out, lnkctl_out, lnkctl2_out;
    logic [31:0] exp_q[$];
    int          n_mismatch = 0, n_compared = 0;
    always #5 mclk_in = ~mclk_in;
    pdl_core_model #(.LINK_STATE(LINK_T)) model (.mclk_in(mclk_in), .por_n_in(por_n_in),
        .err_cmd_in(err_cmd), .eqreq_cmd_in(eqreq_cmd), .pend_cmd_in(pend_cmd), .eqst_cmd_in(eqst_cmd),
        .err_event_out(err_ev), .np_pending_out(np_pend), .link_state_out(link_st),
        .eq_status_out(eq_st), .eq_request_out(eq_req));
    pdl_regs #(.LNKCAP_V(LNKCAP_T)) dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
        .ce_in(1'b1), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .err_event_in(err_ev), .np_pending_in(np_pend), .link_state_in(link_st),
        .eq_status_in(eq_st), .eq_request_in(eq_req), .flr_out(flr_out), .irq_out(irq_out),
        .devctl_out(devctl_out), .devctl2_out(devctl2_out), .lnkctl_out(lnkctl_out),
        .lnkctl2_out(lnkctl2_out));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk32(input string name, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic chk1(input string name, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", name, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask
    // Expected value is queued; the monitor checks it in the answer cycle
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        exp_q.push_back(e);
        @(posedge mclk_in);
        rd_in <= 1'b0;
    endtask
    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // Read data monitor: data only in the cycle after the strobe
    always @(posedge mclk_in) rd_seen <= rd_in;
    always @(negedge mclk_in) begin
        if (rd_seen && exp_q.size() > 0) begin
            chk32("rdata_out", exp_q.pop_front(), rdata_out);
        end else begin
            chk32("rdata_idle", 32'h0, rdata_out);
        end
    end
    initial begin
        cyc(3000);
        n_mismatch++;
        summarize();
    end
    // ==========================================================
    // Main sequence
    initial begin
        cyc(5);
        rst_n_in <= 1'b1;
        por_n_in <= 1'b1;
        rd(PDL_OFF_DEVCTL, PDL_DEVCTL_RST);
        rd(PDL_OFF_DEVCTL2, PDL_DEVCTL2_RST);
        rd(PDL_OFF_LNKCTL2, PDL_LNKCTL2_RST);
        rd(PDL_OFF_LNKCAP, LNKCAP_T);
        rd(PDL_OFF_DEVCAP2, 32'h0000_001F);
        rd(PDL_OFF_LNKCAP2, 32'h0000_0002);
        rd(12'h0FC, 32'h0);
        for (int i = 0; i < 8; i++) begin
            lfsr = nxt(lfsr);
            v = (i == 0) ? (lfsr | 32'h0000_8000) : lfsr;
            wr(PDL_OFF_DEVCTL, v);
            @(negedge mclk_in) chk1("flr_out", v[15], flr_out);
            @(negedge mclk_in) chk1("flr_out", 1'b0, flr_out);
            rd(PDL_OFF_DEVCTL, v & PDL_DEVCTL_WMASK);
            @(negedge mclk_in) chk32("devctl_out", v & PDL_DEVCTL_WMASK, devctl_out);
            wr(PDL_OFF_LNKCTL, v);
            rd(PDL_OFF_LNKCTL, (v & PDL_LNKCTL_WMASK) | {6'h0, LINK_T, 16'h0});
            @(negedge mclk_in) chk32("lnkctl_out", v & PDL_LNKCTL_WMASK, lnkctl_out);
            wr(PDL_OFF_DEVCTL2, v);
            rd(PDL_OFF_DEVCTL2, v & PDL_DEVCTL2_WMASK);
            @(negedge mclk_in) chk32("devctl2_out", v & PDL_DEVCTL2_WMASK, devctl2_out);
            wr(PDL_OFF_LNKCTL2, v);
            rd(PDL_OFF_LNKCTL2, v & (PDL_LNKCTL2_SMASK | PDL_LNKCTL2_WMASK));
            @(negedge mclk_in) chk32("lnkctl2_out", v & (PDL_LNKCTL2_SMASK | PDL_LNKCTL2_WMASK), lnkctl2_out);
            wr(PDL_OFF_LNKCAP, v);
            rd(PDL_OFF_LNKCAP, LNKCAP_T);
        end
        // Events from the core side, interrupt masked at first
        err_cmd <= 4'hF;
        eqreq_cmd <= 1'b1;
        eqst_cmd <= 4'hB;
        pend_cmd <= 1'b1;
        cyc(1);
        err_cmd <= 4'h0;
        eqreq_cmd <= 1'b0;
        cyc(4);
        rd(PDL_OFF_DEVCTL, (v & PDL_DEVCTL_WMASK) | 32'h002F_0000);
        @(negedge mclk_in) chk1("irq_out", 1'b0, irq_out);
        wr(PDL_OFF_INTMASK, 32'h0000_001F);
        cyc(1);
        @(negedge mclk_in) chk1("irq_out", 1'b1, irq_out);
        rd(PDL_OFF_INTSTAT, 32'h0000_001F);
        wr(PDL_OFF_DEVCTL, (v & PDL_DEVCTL_WMASK) | 32'h000F_0000);
        rd(PDL_OFF_DEVCTL, (v & PDL_DEVCTL_WMASK) | 32'h0020_0000);
        rd(PDL_OFF_LNKCTL2, (v & (PDL_LNKCTL2_SMASK | PDL_LNKCTL2_WMASK)) | 32'h0036_0000);
        wr(PDL_OFF_LNKCTL2, v | 32'h003E_0000);
        rd(PDL_OFF_LNKCTL2, (v & (PDL_LNKCTL2_SMASK | PDL_LNKCTL2_WMASK)) | 32'h0016_0000);
        wr(PDL_OFF_INTSTAT, 32'h0000_001F);
        cyc(1);
        @(negedge mclk_in) chk1("irq_out", 1'b0, irq_out);
        pend_cmd <= 1'b0;
        cyc(4);
        rd(PDL_OFF_DEVCTL, v & PDL_DEVCTL_WMASK);
        // Function reset keeps sticky fields, power-on reloads PDL_LNKCTL2_RST into them
        @(posedge mclk_in) rst_n_in <= 1'b0;
        cyc(2);
        rst_n_in <= 1'b1;
        rd(PDL_OFF_LNKCTL2, (v & PDL_LNKCTL2_SMASK) | 32'h0016_0000);
        rd(PDL_OFF_DEVCTL, PDL_DEVCTL_RST);
        @(posedge mclk_in) rst_n_in <= 1'b0;
        por_n_in <= 1'b0;
        cyc(2);
        rst_n_in <= 1'b1;
        por_n_in <= 1'b1;
        cyc(2);
        rd(PDL_OFF_LNKCTL2, PDL_LNKCTL2_RST | 32'h0016_0000);
        cyc(3);
        summarize();
    end
endmodule
